// *** include/sxc_pkg.sv ***
// Purpose: Constants and types for the external bank clock generator.
// Assumes: One 20 MHz clock; software reaches the registers over Avalon-MM.
// Notes: Register offsets are byte addresses on a 32-bit data bus.
package sxc_pkg;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_FACTOR = 5'h04;
	localparam logic [4:0] ADDR_RATE = 5'h08;
	localparam logic [4:0] ADDR_PHASE = 5'h0C;
	localparam logic [4:0] ADDR_BANK = 5'h10;
	localparam logic [4:0] ADDR_DPA_SEL = 5'h14;
	localparam logic [4:0] ADDR_STATUS = 5'h18;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_PHASE_EN_BIT = 8;
	localparam int BANK_SEL_LSB = 0;
	localparam int BANK_RX_LSB = 8;
	localparam int BANK_TX_LSB = 16;
	localparam logic [1:0] MODE_FIXED = 2'h0;
	localparam logic [1:0] MODE_DPA = 2'h1;
	localparam logic [1:0] MODE_CDR = 2'h2;
	localparam logic [3:0] FACTOR_MIN = 4'h3;
	localparam logic [3:0] FACTOR_MAX = 4'hA;
	localparam logic [3:0] FACTOR_RESET = 4'hA;
	localparam logic [7:0] RATE_RESET = 8'h00;
	localparam logic [2:0] STEPS_PER_BIT_LAST = 3'h7;
	localparam logic [6:0] HALF_BIT_STEPS = 7'h04;
	localparam int MCLK_FREQ_MHZ = 20;
	localparam int LOCK_TIME_NS = 10000;
	localparam int LOCK_CYCLES = (LOCK_TIME_NS * MCLK_FREQ_MHZ + 999) / 1000;
	typedef enum logic [2:0] {
		LOCK_IDLE = 3'b001,
		LOCK_ACQUIRE = 3'b010,
		LOCK_DONE = 3'b100
	} sxc_lock_type;
	typedef struct packed {
		logic enable;
		logic [1:0] rx_mode;
		logic phase_en;
		logic [3:0] factor;
		logic [7:0] rate;
		logic [2:0] phase;
		logic [2:0] bank;
		logic [7:0] rx_mask;
		logic [7:0] tx_mask;
		logic [23:0] dpa_sel;
		sxc_lock_type lock_st;
		logic [7:0] lock_cnt;
		logic [7:0] pre;
		logic [2:0] sub;
		logic [3:0] bitc;
		logic wait_req;
		logic [31:0] rdata;
		logic fast;
		logic tx_load;
		logic rx_load;
		logic core;
		logic rx_reset;
		logic [7:0] vco;
		logic [7:0] dpa_clk;
		logic comp_diff;
		logic [7:0] rx_en;
		logic [7:0] tx_en;
		logic locked;
	} sxc_state_type;
endpackage

// *** core/sxc_clock_gen.sv ***
// Purpose: Bank clock generator feeding serializer and deserializer channels.
// Assumes: All inputs synchronous to MCLK_IN; one VCO step per prescaled enable.
// Notes: One bit period is eight VCO steps, so eight phase taps are 45 degrees apart.
`timescale 1ns/1ps
module sxc_clock_gen #(
	parameter int NUM_BANKS = 4,
	parameter int NUM_RX = 4
)
(
	input wire logic MCLK_IN,
	input wire logic RESET_IN,
	input wire logic [4:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	output logic FAST_CLK_OUT,
	output logic TX_LOAD_OUT,
	output logic RX_LOAD_OUT,
	output logic CORE_CLK_OUT,
	output logic RX_PLL_RESET_OUT,
	output logic [7:0] VCO_PHASE_OUT,
	output logic [NUM_RX-1:0] RX_DPA_CLK_OUT,
	output logic COMP_DIFF_OUT,
	output logic [NUM_BANKS-1:0] RX_BANK_EN_OUT,
	output logic [NUM_BANKS-1:0] TX_BANK_EN_OUT,
	output logic LOCKED_OUT
);
	// ==========================================================
	// Parameter checks and reset state
	// ==========================================================
	if (NUM_BANKS < 1 || NUM_BANKS > 8 || NUM_RX < 1 || NUM_RX > 8)
	begin : g_bad_param
		$error("Bank and receiver counts must lie between one and eight.");
	end

	// Compensation tracks the receiver mode, which resets to fixed phase, so it starts differential.
	localparam sxc_pkg::sxc_state_type RESET_STATE = '{
		enable: 1'b0, rx_mode: sxc_pkg::MODE_FIXED, phase_en: 1'b0,
		factor: sxc_pkg::FACTOR_RESET, rate: sxc_pkg::RATE_RESET, phase: 3'h0,
		bank: 3'h0, rx_mask: 8'h00, tx_mask: 8'h00, dpa_sel: 24'h000000,
		lock_st: sxc_pkg::LOCK_IDLE, lock_cnt: 8'h00, pre: 8'h00, sub: 3'h0,
		bitc: 4'h0, wait_req: 1'b1, rdata: 32'h00000000, fast: 1'b0,
		tx_load: 1'b0, rx_load: 1'b0, core: 1'b0, rx_reset: 1'b1, vco: 8'h00,
		dpa_clk: 8'h00, comp_diff: 1'b1, rx_en: 8'h00, tx_en: 8'h00, locked: 1'b0
	};

	sxc_pkg::sxc_state_type st_q;
	sxc_pkg::sxc_state_type st_d;
	logic [7:0] own_mask;
	logic [7:0] allowed_mask;
	logic [7:0] bank_limit;
	logic rx_err;
	logic tx_err;
	logic cfg_write;

	// ==========================================================
	// Bank placement checks
	// ==========================================================
	always_comb
	begin
		bank_limit = 8'((9'h001 << NUM_BANKS) - 9'h001);
		own_mask = 8'(8'h01 << st_q.bank) & bank_limit;
		// A neighbour on either side may take transmitters, never receivers.
		allowed_mask = (own_mask | 8'(own_mask << 1) | 8'(own_mask >> 1)) & bank_limit;
		rx_err = |(st_q.rx_mask & ~own_mask);
		tx_err = |(st_q.tx_mask & ~allowed_mask);
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		logic [31:0] cur;
		logic [31:0] nw;
		logic acc;
		logic step;
		logic live;
		logic aligning;
		logic [2:0] s;
		logic [2:0] diff;
		logic [6:0] pos;
		logic [6:0] core_end;
		logic [7:0] taps;
		cur = 32'h00000000;
		nw = 32'h00000000;
		taps = 8'h00;
		diff = 3'h0;
		acc = 1'b0;
		step = 1'b0;
		live = 1'b0;
		aligning = 1'b0;
		s = 3'h0;
		pos = 7'h00;
		core_end = 7'h00;
		st_d = st_q;
		cfg_write = 1'b0;
		// Bus slave: one wait cycle, then the access completes on the low-wait edge.
		acc = (AVS_READ_IN || AVS_WRITE_IN) && !st_q.wait_req;
		st_d.wait_req = !((AVS_READ_IN || AVS_WRITE_IN) && st_q.wait_req);
		st_d.rdata = 32'h00000000;
		if (AVS_ADDRESS_IN == sxc_pkg::ADDR_CTRL)
		begin
			cur[sxc_pkg::CTRL_ENABLE_BIT] = st_q.enable;
			cur[sxc_pkg::CTRL_MODE_LSB +: 2] = st_q.rx_mode;
			cur[sxc_pkg::CTRL_PHASE_EN_BIT] = st_q.phase_en;
		end
		else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_FACTOR)
		begin
			cur[3:0] = st_q.factor;
		end
		else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_RATE)
		begin
			cur[7:0] = st_q.rate;
		end
		else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_PHASE)
		begin
			cur[2:0] = st_q.phase;
		end
		else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_BANK)
		begin
			cur[sxc_pkg::BANK_SEL_LSB +: 3] = st_q.bank;
			cur[sxc_pkg::BANK_RX_LSB +: 8] = st_q.rx_mask;
			cur[sxc_pkg::BANK_TX_LSB +: 8] = st_q.tx_mask;
		end
		else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_DPA_SEL)
		begin
			cur[23:0] = st_q.dpa_sel;
		end
		else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_STATUS)
		begin
			cur[3:0] = {tx_err, rx_err, !(rx_err || tx_err), st_q.locked};
			cur[6:4] = st_q.lock_st;
		end
		if ((AVS_READ_IN || AVS_WRITE_IN) && st_q.wait_req)
		begin
			st_d.rdata = cur;
		end
		nw = merge(cur, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
		if (acc && AVS_WRITE_IN)
		begin
			if (AVS_ADDRESS_IN == sxc_pkg::ADDR_CTRL)
			begin
				st_d.enable = nw[sxc_pkg::CTRL_ENABLE_BIT];
				if (nw[sxc_pkg::CTRL_MODE_LSB +: 2] != 2'h3)
				begin
					st_d.rx_mode = nw[sxc_pkg::CTRL_MODE_LSB +: 2];
				end
				st_d.phase_en = nw[sxc_pkg::CTRL_PHASE_EN_BIT];
				cfg_write = 1'b1;
			end
			else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_FACTOR)
			begin
				// Out-of-range factors are ignored so the word timing stays defined.
				if (nw[3:0] >= sxc_pkg::FACTOR_MIN && nw[3:0] <= sxc_pkg::FACTOR_MAX)
				begin
					st_d.factor = nw[3:0];
				end
				cfg_write = 1'b1;
			end
			else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_RATE)
			begin
				st_d.rate = nw[7:0];
				cfg_write = 1'b1;
			end
			else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_PHASE)
			begin
				st_d.phase = nw[2:0];
			end
			else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_BANK)
			begin
				st_d.bank = nw[sxc_pkg::BANK_SEL_LSB +: 3];
				st_d.rx_mask = nw[sxc_pkg::BANK_RX_LSB +: 8];
				st_d.tx_mask = nw[sxc_pkg::BANK_TX_LSB +: 8];
				cfg_write = 1'b1;
			end
			else if (AVS_ADDRESS_IN == sxc_pkg::ADDR_DPA_SEL)
			begin
				st_d.dpa_sel = nw[23:0];
			end
		end

		// Lock model: any change of frequency plan drops lock and waits again.
		case (st_q.lock_st)
			sxc_pkg::LOCK_IDLE:
			begin
				st_d.lock_cnt = 8'h00;
				if (st_q.enable)
				begin
					st_d.lock_st = sxc_pkg::LOCK_ACQUIRE;
				end
			end
			sxc_pkg::LOCK_ACQUIRE:
			begin
				st_d.lock_cnt = st_q.lock_cnt + 8'h01;
				if (st_q.lock_cnt == 8'(sxc_pkg::LOCK_CYCLES - 1))
				begin
					st_d.lock_st = sxc_pkg::LOCK_DONE;
				end
			end
			sxc_pkg::LOCK_DONE:
			begin
				st_d.lock_cnt = 8'h00;
			end
			default:
			begin
				st_d.lock_st = sxc_pkg::LOCK_IDLE;
			end
		endcase
		if (!st_q.enable)
		begin
			st_d.lock_st = sxc_pkg::LOCK_IDLE;
		end
		else if (cfg_write)
		begin
			st_d.lock_st = sxc_pkg::LOCK_ACQUIRE;
			st_d.lock_cnt = 8'h00;
		end

		// Phase generator; held at word start while unlocked so words restart aligned.
		live = (st_q.lock_st == sxc_pkg::LOCK_DONE);
		step = (st_q.pre == st_q.rate);
		if (!live)
		begin
			st_d.pre = 8'h00;
			st_d.sub = 3'h0;
			st_d.bitc = 4'h0;
		end
		else
		begin
			st_d.pre = step ? 8'h00 : st_q.pre + 8'h01;
			if (step)
			begin
				st_d.sub = st_q.sub + 3'h1;
				if (st_q.sub == sxc_pkg::STEPS_PER_BIT_LAST)
				begin
					st_d.bitc = (st_q.bitc == st_q.factor - 4'h1) ? 4'h0 : st_q.bitc + 4'h1;
				end
			end
		end
		s = st_q.sub + st_q.phase;
		for (int k = 0; k < 8; k++)
		begin
			diff = s - 3'(k);
			taps[k] = !diff[2];
		end
		pos = {st_q.bitc, st_q.sub};
		core_end = sxc_pkg::HALF_BIT_STEPS + {1'b0, st_q.factor, 2'b00};
		aligning = (st_q.rx_mode == sxc_pkg::MODE_DPA) || (st_q.rx_mode == sxc_pkg::MODE_CDR);
		// Nothing toggles before lock, so channels never see a partial word.
		st_d.fast = live && st_q.sub[2];
		st_d.tx_load = live && (st_q.bitc == st_q.factor - 4'h1);
		st_d.rx_load = st_d.tx_load && (st_q.rx_mode != sxc_pkg::MODE_CDR);
		st_d.core = live && pos >= sxc_pkg::HALF_BIT_STEPS && pos < core_end;
		st_d.rx_reset = !live;
		st_d.locked = live;
		st_d.vco = (live && aligning && st_q.phase_en) ? taps : 8'h00;
		for (int c = 0; c < 8; c++)
		begin
			st_d.dpa_clk[c] = live && aligning && taps[st_q.dpa_sel[c*3 +: 3]];
		end
		st_d.comp_diff = (st_q.rx_mode == sxc_pkg::MODE_FIXED);
		// An invalid receiver or transmitter placement enables none of that direction's banks rather than a partial set.
		st_d.rx_en = (live && !rx_err) ? st_q.rx_mask : 8'h00;
		st_d.tx_en = (live && !tx_err) ? st_q.tx_mask : 8'h00;
	end

	always_ff @(posedge MCLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			st_q <= RESET_STATE;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign AVS_READDATA_OUT = st_q.rdata;
	assign AVS_WAITREQUEST_OUT = st_q.wait_req;
	assign FAST_CLK_OUT = st_q.fast;
	assign TX_LOAD_OUT = st_q.tx_load;
	assign RX_LOAD_OUT = st_q.rx_load;
	assign CORE_CLK_OUT = st_q.core;
	assign RX_PLL_RESET_OUT = st_q.rx_reset;
	assign VCO_PHASE_OUT = st_q.vco;
	assign RX_DPA_CLK_OUT = st_q.dpa_clk[NUM_RX-1:0];
	assign COMP_DIFF_OUT = st_q.comp_diff;
	assign RX_BANK_EN_OUT = st_q.rx_en[NUM_BANKS-1:0];
	assign TX_BANK_EN_OUT = st_q.tx_en[NUM_BANKS-1:0];
	assign LOCKED_OUT = st_q.locked;

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (RESET_IN);

	AST_RX_OWN_BANK: assert property (($past(st_q.rx_en) & ~$past(own_mask)) == 8'h00)
		else $error("Receiver enabled outside the own bank.");
	AST_TX_ADJACENT: assert property (($past(st_q.tx_en) & ~$past(allowed_mask)) == 8'h00)
		else $error("Transmitter enabled in a non-adjacent bank.");
	AST_RX_SINGLE_BANK: assert property ($onehot0(RX_BANK_EN_OUT))
		else $error("Receivers enabled in more than one bank.");
	AST_DPA_TAP: assert property ($past(st_q.phase_en) && VCO_PHASE_OUT != 8'h00
		|-> RX_DPA_CLK_OUT[0] == VCO_PHASE_OUT[$past(st_q.dpa_sel[2:0])])
		else $error("Channel phase clock does not follow its selected tap.");
	AST_COMP_MODE: assert property (COMP_DIFF_OUT == ($past(st_q.rx_mode) == sxc_pkg::MODE_FIXED))
		else $error("Compensation mode does not match receiver mode.");
	AST_CDR_NO_LOAD: assert property ($past(st_q.rx_mode) == sxc_pkg::MODE_CDR |-> !RX_LOAD_OUT)
		else $error("Load strobe sent to a clock recovery receiver.");
	AST_VCO_FIXED_OFF: assert property ($past(st_q.rx_mode) == sxc_pkg::MODE_FIXED |-> VCO_PHASE_OUT == 8'h00)
		else $error("Phase taps driven for a fixed-phase receiver.");
	AST_RESET_UNLOCK: assert property (RX_PLL_RESET_OUT == !LOCKED_OUT)
		else $error("Receiver reset is not the inverse of lock.");
	AST_HOLD_UNLOCKED: assert property (!LOCKED_OUT |-> !FAST_CLK_OUT && !TX_LOAD_OUT && !CORE_CLK_OUT)
		else $error("Clock activity while unlocked.");
	AST_FAST_HALF: assert property (@(posedge MCLK_IN) disable iff (RESET_IN || st_q.lock_st != sxc_pkg::LOCK_DONE)
		$rose(FAST_CLK_OUT) && st_q.rate == 8'h00 |-> FAST_CLK_OUT [*4] ##1 !FAST_CLK_OUT)
		else $error("Bit clock high time is not half a bit.");
	AST_LOAD_ONE_BIT: assert property (@(posedge MCLK_IN) disable iff (RESET_IN || st_q.lock_st != sxc_pkg::LOCK_DONE)
		$rose(TX_LOAD_OUT) && st_q.rate == 8'h00 |-> TX_LOAD_OUT [*8] ##1 !TX_LOAD_OUT)
		else $error("Load strobe is not one bit period long.");
	AST_FACTOR_RANGE: assert property (st_q.factor >= sxc_pkg::FACTOR_MIN && st_q.factor <= sxc_pkg::FACTOR_MAX)
		else $error("Serialization factor out of range.");
	AST_RELOCK: assert property (cfg_write && st_q.enable |-> ##[1:2] !LOCKED_OUT)
		else $error("Lock kept across a frequency plan change.");
	AST_BUS_ANSWER: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
		else $error("Bus request not answered after one wait cycle.");

	COV_LOCK: cover property ($rose(LOCKED_OUT));
	COV_LOAD: cover property ($rose(TX_LOAD_OUT));
	COV_CDR_LIVE: cover property (LOCKED_OUT && VCO_PHASE_OUT != 8'h00 && !RX_LOAD_OUT);
	COV_BAD_BANK: cover property (tx_err && LOCKED_OUT);
endmodule

// *** testbench/sxc_chan_model.sv ***
// Purpose: Far-side channel model that measures the clocks and strobe it is fed.
// Assumes: All inputs change on MCLK_IN edges; figures are counted in MCLK_IN cycles.
// Notes: Figures hold their last value while the channel is held in reset.
`timescale 1ns/1ps
module sxc_chan_model
(
	input wire logic mclk_in,
	input wire logic fast_in,
	input wire logic load_in,
	input wire logic core_in,
	input wire logic rst_in,
	output int fast_per_out,
	output int fast_hi_out,
	output int load_per_out,
	output int load_hi_out,
	output int core_hi_out,
	output int core_to_load_out
);
	// =====================================================================
	// Edge timing
	// Sampling at bit centre is only right for edge-aligned clock and data.
	int cyc = 0;
	int f_r = 0;
	int l_r = 0;
	int c_r = 0;
	logic f_p = 1'b0;
	logic l_p = 1'b0;
	logic c_p = 1'b0;
	always @(posedge mclk_in)
	begin
		cyc <= cyc + 1;
		f_p <= fast_in;
		l_p <= load_in;
		c_p <= core_in;
		// The channel ignores every clock while its receiver reset stands.
		if (!rst_in)
		begin
			if (fast_in && !f_p)
			begin
				fast_per_out <= cyc - f_r;
				f_r <= cyc;
			end
			if (!fast_in && f_p)
				fast_hi_out <= cyc - f_r;
			if (load_in && !l_p)
			begin
				load_per_out <= cyc - l_r;
				core_to_load_out <= cyc - c_r;
				l_r <= cyc;
			end
			if (!load_in && l_p)
				load_hi_out <= cyc - l_r;
			if (core_in && !c_p)
				c_r <= cyc;
			if (!core_in && c_p)
				core_hi_out <= cyc - c_r;
		end
	end
endmodule

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the bank clock generator.
// Assumes: RATE=0 gives one VCO step per cycle, eight steps per bit.
// Notes: Lock takes about 200 cycles, so every relock costs a bounded wait.
`timescale 1ns/1ps
module tb;
	logic MCLK_IN = 1'b0;
	logic RESET_IN = 1'b1;
	logic [4:0] addr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, q;
	logic wreq, fast, txl, rxl, core, rxrst, comp, locked;
	logic [7:0] vco;
	logic [3:0] dynamic_phase_align, rxen, txen;
	int fp, fh, lp, lh, ch, cl;
	int miscompares = 0;
	int comparisons = 0;
	logic rxl_seen, txl_seen, vco_seen, dpa_bad;
	always #25 MCLK_IN = ~MCLK_IN;
	sxc_clock_gen #(.NUM_BANKS(4), .NUM_RX(4)) uut (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN),
		.AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(4'hF),
		.AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq),
		.FAST_CLK_OUT(fast), .TX_LOAD_OUT(txl), .RX_LOAD_OUT(rxl), .CORE_CLK_OUT(core),
		.RX_PLL_RESET_OUT(rxrst), .VCO_PHASE_OUT(vco), .RX_DPA_CLK_OUT(dynamic_phase_align), .COMP_DIFF_OUT(comp),
		.RX_BANK_EN_OUT(rxen), .TX_BANK_EN_OUT(txen), .LOCKED_OUT(locked));
	sxc_chan_model chan (.mclk_in(MCLK_IN), .fast_in(fast), .load_in(txl), .core_in(core),
		.rst_in(rxrst), .fast_per_out(fp), .fast_hi_out(fh), .load_per_out(lp),
		.load_hi_out(lh), .core_hi_out(ch), .core_to_load_out(cl));
	// =====================================================================
	// Shared tasks
	task automatic report_and_stop();
	begin
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %0h want %0h", $time, got, exp);
		end
	end
	endtask
	// The request stands until waitrequest is sampled low; a slave still busy after 20 edges fails the bench.
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
	begin
		n = 0;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do
		begin
			@(posedge MCLK_IN);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (wreq !== 1'b0)
		begin
			cmp(32'h1, 32'h0);
			report_and_stop();
		end
		@(posedge MCLK_IN);
	end
	endtask
	task automatic wait_lock();
		int n;
	begin
		n = 0;
		// A relock shows on the lock output only two edges after the write completes.
		repeat (2) @(posedge MCLK_IN);
		while (locked !== 1'b1 && n < 400)
		begin
			@(posedge MCLK_IN);
			n++;
		end
		if (n >= 400)
		begin
			cmp(32'h1, 32'h0);
			report_and_stop();
		end
	end
	endtask
	task automatic watch(input int n);
	begin
		{rxl_seen, txl_seen, vco_seen, dpa_bad} = 4'h0;
		repeat (n)
		begin
			@(posedge MCLK_IN);
			rxl_seen |= rxl;
			txl_seen |= txl;
			vco_seen |= (vco != 8'h00);
			dpa_bad |= (dynamic_phase_align[1] !== vco[4]);
		end
	end
	endtask
	// =====================================================================
	// Scenarios
	task automatic t_reset();
	begin
		cmp({wreq, rxrst, locked, fast, txl, rxl, core, vco, rxen, txen}, 32'h00600000);
	end
	endtask
	task automatic t_regs();
	begin
		bus(1'b0, 5'h04, 32'h0);
		cmp(q, 32'h0000000A);
		bus(1'b0, 5'h08, 32'h0);
		cmp(q, 32'h00000000);
		bus(1'b0, 5'h18, 32'h0);
		cmp(q & 32'h71, 32'h10);
		bus(1'b1, 5'h1C, 32'hFFFFFFFF);
		bus(1'b0, 5'h1C, 32'h0);
		cmp(q, 32'h0);
	end
	endtask
	task automatic t_fixed();
	begin
		bus(1'b1, 5'h04, 32'h3);
		bus(1'b1, 5'h10, 32'h00070201);
		bus(1'b1, 5'h00, 32'h1);
		wait_lock();
		watch(80);
		cmp({rxrst, comp, rxen, txen}, 32'h00000127);
		cmp(vco_seen, 32'h0);
		bus(1'b0, 5'h18, 32'h0);
		cmp(q & 32'h73, 32'h43);
		cmp(fp, 8);
		cmp(fh, 4);
		cmp(lp, 24);
		cmp(lh, 8);
		cmp(ch, 12);
		cmp(cl, 12);
	end
	endtask
	task automatic t_factor();
	begin
		bus(1'b1, 5'h04, 32'hB);
		bus(1'b0, 5'h04, 32'h0);
		cmp(q, 32'h3);
		bus(1'b1, 5'h04, 32'hA);
		wait_lock();
		watch(200);
		cmp(lp, 80);
		cmp(lh, 8);
		cmp(ch, 40);
	end
	endtask
	task automatic t_cdr();
	begin
		bus(1'b1, 5'h00, 32'h121);
		wait_lock();
		watch(100);
		cmp({rxl_seen, txl_seen, vco_seen, comp, rxrst}, 32'h0C);
	end
	endtask
	task automatic t_dpa();
	begin
		bus(1'b1, 5'h14, 32'h20);
		bus(1'b1, 5'h00, 32'h111);
		wait_lock();
		watch(100);
		cmp({rxl_seen, txl_seen, vco_seen, dpa_bad, rxrst}, 32'h1C);
	end
	endtask
	task automatic t_place();
	begin
		bus(1'b1, 5'h10, 32'h000B0601);
		wait_lock();
		repeat (4) @(posedge MCLK_IN);
		cmp({rxen, txen}, 32'h0);
		bus(1'b0, 5'h18, 32'h0);
		cmp(q & 32'hE, 32'hC);
	end
	endtask
	task automatic t_rate();
	begin
		bus(1'b1, 5'h08, 32'h1);
		wait_lock();
		watch(100);
		cmp(fp, 16);
		cmp(fh, 8);
	end
	endtask
	task automatic t_off();
	begin
		bus(1'b1, 5'h00, 32'h0);
		repeat (4) @(posedge MCLK_IN);
		cmp({locked, rxrst, fast, txl, core}, 32'h08);
	end
	endtask
	// =====================================================================
	// Main sequence
	initial
	begin
		repeat (16) @(posedge MCLK_IN);
		RESET_IN <= 1'b0;
		@(posedge MCLK_IN);
		t_reset();
		t_regs();
		t_fixed();
		t_factor();
		t_cdr();
		t_dpa();
		t_place();
		t_rate();
		t_off();
		report_and_stop();
	end
endmodule
